// file: verilog/fsac_flash_guard.sv
// How it works
// - A read-lock bit at 0 stops JTAG reads of its block; 1 allows.
// - A write-lock bit at 0 stops JTAG writes and erases of its block.
// - At reset the read limit is the limit byte followed by a zero byte.
// - Lower partition is below the limit; upper is at or above it.
// - Upper-partition code cannot read, write or erase below the limit.
// - A refused read answers with byte zero, not the stored contents.
// - Instruction fetches into the lower partition are always allowed.
// - Lower-partition code may access every location freely, except that it cannot erase the security page.
// - The limit lands on any 256-byte boundary; 512-byte alignment is advised.
// - An unprogrammed limit byte is zero, leaving all memory readable.
// - Lock bytes stay readable and can always be cleared toward zero.
// - Only a JTAG mass erase or a JTAG erase of the security page sets lock bits back to one.
// - Erasing a security byte starts a full erase, from JTAG only.
// - Erasing the security page by another byte erases the security bytes too.
// - Control register bits seven to two read zero and ignore writes.
// - Erase plus write enable makes a data-move write erase its page.
// - Write enable alone makes a data-move write program one byte.
module fsac_flash_guard (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic core_req_in,
  input wire logic [1:0] core_op_in,
  input wire logic [15:0] core_pc_in,
  input wire logic [15:0] core_addr_in,
  input wire logic [7:0] core_wdata_in,
  output logic core_ready_out,
  output logic core_rvalid_out,
  output logic [7:0] core_rdata_out,
  output logic core_denied_out,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic jtag_req_in,
  input wire logic [1:0] jtag_op_in,
  input wire logic [15:0] jtag_addr_in,
  input wire logic [7:0] jtag_wdata_in,
  output logic jtag_ready_out,
  output logic jtag_rvalid_out,
  output logic [7:0] jtag_rdata_out,
  output logic jtag_denied_out,
  input wire logic flash_busy_in,
  input wire logic [7:0] flash_rdata_in,
  output logic flash_rd_out,
  output logic flash_prog_out,
  output logic flash_page_erase_out,
  output logic flash_mass_erase_out,
  output logic [15:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic guard_ready_out,
  output logic [15:0] software_read_limit_out
);

  fsac_pkg::fsac_state_t state_r;
  logic [1:0] load_idx_r;
  logic [fsac_pkg::PSC_USED_W-1:0] program_store_control_r;
  logic [7:0] access_limit_byte_r;
  logic [7:0] read_lock_r;
  logic [7:0] write_lock_r;
  logic [15:0] software_read_limit;
  logic flash_rd_r;
  logic flash_prog_r;
  logic page_erase_r;
  logic mass_erase_r;
  logic [15:0] flash_addr_r;
  logic [7:0] flash_wdata_r;
  logic pend1_v_r;
  logic pend1_jtag_r;
  logic pend1_blk_r;
  logic pend2_v_r;
  logic pend2_jtag_r;
  logic pend2_blk_r;
  logic core_rvalid_r;
  logic [7:0] core_rdata_r;
  logic jtag_rvalid_r;
  logic [7:0] jtag_rdata_r;
  logic core_denied_r;
  logic jtag_denied_r;
  logic [7:0] sfr_rdata_r;
  logic run;
  logic cmd_pending;
  logic accept_core;
  logic accept_jtag;
  logic flash_write_enable;
  logic page_erase_enable;
  logic rd_go;
  logic prog_go;
  logic perase_go;
  logic merase_go;
  logic rsp_blk;
  logic is_read;
  logic lock_clear;
  logic lock_reopen;
  logic denied;
  logic [15:0] req_addr;
  logic [7:0] req_wdata;

  fsac_chk_if chk();

  assign software_read_limit = {access_limit_byte_r, fsac_pkg::LIMIT_LOW_BYTE};

  assign chk.read_limit = software_read_limit;
  assign chk.read_lock = read_lock_r;
  assign chk.write_lock = write_lock_r;
  assign chk.core_pc = core_pc_in;
  assign chk.core_addr = core_addr_in;
  assign chk.jtag_addr = jtag_addr_in;

  fsac_check #(
    .BLOCK_SHIFT(fsac_pkg::BLOCK_SHIFT)
  ) u_check (
    .chk(chk)
  );

  assign run = (state_r == fsac_pkg::S_RUN);
  assign flash_write_enable = program_store_control_r[fsac_pkg::PSC_WE_BIT];
  assign page_erase_enable = program_store_control_r[fsac_pkg::PSC_EE_BIT];

  // One program or erase in flight to the array; the pending strobe, then busy, covers its duration
  assign cmd_pending = flash_prog_r | page_erase_r | mass_erase_r;
  assign core_ready_out = run && !flash_busy_in && !cmd_pending;
  assign jtag_ready_out = core_ready_out && !core_req_in;
  assign accept_core = core_req_in && core_ready_out;
  assign accept_jtag = jtag_req_in && jtag_ready_out;

  assign req_addr = accept_jtag ? jtag_addr_in : core_addr_in;
  assign req_wdata = accept_jtag ? jtag_wdata_in : core_wdata_in;

  always_comb begin
    rd_go = 1'b0;
    prog_go = 1'b0;
    perase_go = 1'b0;
    merase_go = 1'b0;
    rsp_blk = 1'b0;
    is_read = 1'b0;
    lock_clear = 1'b0;
    lock_reopen = 1'b0;
    denied = 1'b0;
    if (accept_core) begin
      case (fsac_pkg::fsac_core_op_t'(core_op_in))
        fsac_pkg::CORE_FETCH: begin
          is_read = 1'b1;
          rd_go = 1'b1;
        end
        fsac_pkg::CORE_TABLE_READ: begin
          is_read = 1'b1;
          if (chk.core_blocked && !chk.core_is_lock) begin
            rsp_blk = 1'b1;
            denied = 1'b1;
          end else begin
            rd_go = 1'b1;
          end
        end
        fsac_pkg::CORE_DATA_MOVE_WRITE: begin
          // Write enable low: the write simply does not reach flash
          if (flash_write_enable && page_erase_enable) begin
            // Security page erase is a JTAG-only operation
            if (chk.core_blocked || chk.core_sec_page) begin
              denied = 1'b1;
            end else begin
              perase_go = 1'b1;
            end
          end else if (flash_write_enable) begin
            if (chk.core_is_lock) begin
              prog_go = 1'b1;
              lock_clear = 1'b1;
            end else if (chk.core_blocked) begin
              denied = 1'b1;
            end else begin
              prog_go = 1'b1;
            end
          end
        end
        default: begin
          denied = 1'b1;
        end
      endcase
    end else if (accept_jtag) begin
      case (fsac_pkg::fsac_jtag_op_t'(jtag_op_in))
        fsac_pkg::JT_READ: begin
          is_read = 1'b1;
          if (chk.jtag_read_ok) begin
            rd_go = 1'b1;
          end else begin
            rsp_blk = 1'b1;
            denied = 1'b1;
          end
        end
        fsac_pkg::JT_WRITE: begin
          if (chk.jtag_write_ok) begin
            prog_go = 1'b1;
            lock_clear = chk.jtag_is_lock;
          end else begin
            denied = 1'b1;
          end
        end
        fsac_pkg::JT_ERASE: begin
          if (chk.jtag_sec_byte) begin
            merase_go = 1'b1;
            lock_reopen = 1'b1;
          end else if (!chk.jtag_write_ok) begin
            denied = 1'b1;
          end else begin
            perase_go = 1'b1;
            lock_reopen = chk.jtag_sec_page;
          end
        end
        fsac_pkg::JT_MASS_ERASE: begin
          merase_go = 1'b1;
          lock_reopen = 1'b1;
        end
        default: begin
          denied = 1'b1;
        end
      endcase
    end
  end

  // Security bytes are read out of the array before any access is taken
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= fsac_pkg::S_ISSUE;
      load_idx_r <= 2'h0;
    end else begin
      case (state_r)
        fsac_pkg::S_ISSUE: begin
          state_r <= fsac_pkg::S_WAIT;
        end
        fsac_pkg::S_WAIT: begin
          state_r <= fsac_pkg::S_CAPT;
        end
        fsac_pkg::S_CAPT: begin
          if (load_idx_r == 2'(fsac_pkg::LOAD_BYTES - 1)) begin
            state_r <= fsac_pkg::S_RUN;
          end else begin
            load_idx_r <= load_idx_r + 2'h1;
            state_r <= fsac_pkg::S_ISSUE;
          end
        end
        default: begin
          state_r <= fsac_pkg::S_RUN;
        end
      endcase
    end
  end

  function automatic logic [15:0] load_addr(input logic [1:0] idx);
    case (idx)
      2'h0: load_addr = fsac_pkg::LIMIT_BYTE_ADDR;
      2'h1: load_addr = fsac_pkg::READ_LOCK_ADDR;
      default: load_addr = fsac_pkg::WRITE_LOCK_ADDR;
    endcase
  endfunction

  // Locks start closed so nothing leaks before the load completes
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      access_limit_byte_r <= fsac_pkg::LIMIT_UNPROG;
      read_lock_r <= fsac_pkg::LOCK_RESET;
      write_lock_r <= fsac_pkg::LOCK_RESET;
    end else if (state_r == fsac_pkg::S_CAPT) begin
      case (load_idx_r)
        2'h0: access_limit_byte_r <= flash_rdata_in;
        2'h1: read_lock_r <= flash_rdata_in;
        default: write_lock_r <= flash_rdata_in;
      endcase
    end else if (lock_reopen) begin
      read_lock_r <= fsac_pkg::LOCK_OPEN;
      write_lock_r <= fsac_pkg::LOCK_OPEN;
    end else if (lock_clear) begin
      // Programming only clears bits, so a lock can tighten but never relax
      if (req_addr == fsac_pkg::READ_LOCK_ADDR) begin
        read_lock_r <= read_lock_r & req_wdata;
      end else begin
        write_lock_r <= write_lock_r & req_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_rd_r <= 1'b0;
      flash_prog_r <= 1'b0;
      page_erase_r <= 1'b0;
      mass_erase_r <= 1'b0;
      flash_addr_r <= 16'h0000;
      flash_wdata_r <= 8'h00;
    end else if (state_r == fsac_pkg::S_ISSUE) begin
      flash_rd_r <= 1'b1;
      flash_prog_r <= 1'b0;
      page_erase_r <= 1'b0;
      mass_erase_r <= 1'b0;
      flash_addr_r <= load_addr(load_idx_r);
    end else begin
      // Refused requests raise no strobe at all
      flash_rd_r <= rd_go;
      flash_prog_r <= prog_go;
      page_erase_r <= perase_go;
      mass_erase_r <= merase_go;
      if (accept_core || accept_jtag) begin
        flash_addr_r <= req_addr;
        flash_wdata_r <= req_wdata;
      end
    end
  end

  // Read answer pipe: strobe, array data, registered answer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend1_v_r <= 1'b0;
      pend1_jtag_r <= 1'b0;
      pend1_blk_r <= 1'b0;
      pend2_v_r <= 1'b0;
      pend2_jtag_r <= 1'b0;
      pend2_blk_r <= 1'b0;
    end else begin
      pend1_v_r <= is_read;
      pend1_jtag_r <= accept_jtag;
      pend1_blk_r <= rsp_blk;
      pend2_v_r <= pend1_v_r;
      pend2_jtag_r <= pend1_jtag_r;
      pend2_blk_r <= pend1_blk_r;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_rvalid_r <= 1'b0;
      core_rdata_r <= 8'h00;
      jtag_rvalid_r <= 1'b0;
      jtag_rdata_r <= 8'h00;
    end else begin
      core_rvalid_r <= pend2_v_r && !pend2_jtag_r;
      jtag_rvalid_r <= pend2_v_r && pend2_jtag_r;
      if (pend2_v_r && !pend2_jtag_r) begin
        core_rdata_r <= pend2_blk_r ? fsac_pkg::BLOCKED_DATA : flash_rdata_in;
      end
      if (pend2_v_r && pend2_jtag_r) begin
        jtag_rdata_r <= pend2_blk_r ? fsac_pkg::BLOCKED_DATA : flash_rdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_denied_r <= 1'b0;
      jtag_denied_r <= 1'b0;
    end else begin
      core_denied_r <= denied && accept_core;
      jtag_denied_r <= denied && accept_jtag;
    end
  end

  // Program-store control: only the two low bits exist
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      program_store_control_r <= fsac_pkg::PSC_RESET[fsac_pkg::PSC_USED_W-1:0];
    end else if (sfr_wr_in && (sfr_addr_in == fsac_pkg::PSC_OFFSET)) begin
      program_store_control_r <= sfr_wdata_in[fsac_pkg::PSC_USED_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd_in) begin
      if (sfr_addr_in == fsac_pkg::PSC_OFFSET) begin
        sfr_rdata_r <= {{(8 - fsac_pkg::PSC_USED_W){1'b0}}, program_store_control_r};
      end else begin
        sfr_rdata_r <= 8'h00;
      end
    end
  end

  assign core_rvalid_out = core_rvalid_r;
  assign core_rdata_out = core_rdata_r;
  assign core_denied_out = core_denied_r;
  assign jtag_rvalid_out = jtag_rvalid_r;
  assign jtag_rdata_out = jtag_rdata_r;
  assign jtag_denied_out = jtag_denied_r;
  assign sfr_rdata_out = sfr_rdata_r;
  assign flash_rd_out = flash_rd_r;
  assign flash_prog_out = flash_prog_r;
  assign flash_page_erase_out = page_erase_r;
  assign flash_mass_erase_out = mass_erase_r;
  assign flash_addr_out = flash_addr_r;
  assign flash_wdata_out = flash_wdata_r;
  assign guard_ready_out = run;
  assign software_read_limit_out = software_read_limit;

endmodule // fsac_flash_guard

// file: verilog/fsac_pkg.sv
package fsac_pkg;

  // Program-store control register
  localparam logic [7:0] PSC_OFFSET = 8'h8F;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int PSC_WE_BIT = 0;
  localparam int PSC_EE_BIT = 1;
  localparam int PSC_USED_W = 2;

  // Security page and the bytes kept in it
  localparam logic [15:0] SEC_PAGE_BASE = 16'h1C00;
  localparam logic [15:0] SEC_PAGE_LAST = 16'h1DFF;
  localparam logic [15:0] READ_LOCK_ADDR = 16'h1DFF;
  localparam logic [15:0] WRITE_LOCK_ADDR = 16'h1DFE;
  localparam logic [15:0] LIMIT_BYTE_ADDR = 16'h1DFD;

  // Values
  localparam logic [7:0] LOCK_OPEN = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] LIMIT_UNPROG = 8'h00;
  localparam logic [7:0] LIMIT_LOW_BYTE = 8'h00;
  localparam logic [7:0] BLOCKED_DATA = 8'h00;

  // Geometry: eight lock blocks of 1 KB each
  localparam int ADDR_W = 16;
  localparam int BLOCK_SHIFT = 10;
  localparam int BLOCK_IDX_W = 3;
  localparam int LOAD_BYTES = 3;

  typedef enum logic [1:0] {
    S_ISSUE = 2'b00,
    S_WAIT = 2'b01,
    S_CAPT = 2'b10,
    S_RUN = 2'b11
  } fsac_state_t;

  typedef enum logic [1:0] {
    CORE_FETCH = 2'b00,
    CORE_TABLE_READ = 2'b01,
    CORE_DATA_MOVE_WRITE = 2'b10
  } fsac_core_op_t;

  typedef enum logic [1:0] {
    JT_READ = 2'b00,
    JT_WRITE = 2'b01,
    JT_ERASE = 2'b10,
    JT_MASS_ERASE = 2'b11
  } fsac_jtag_op_t;

endpackage

// file: verilog/fsac_chk_if.sv
interface fsac_chk_if;
  logic [15:0] read_limit;
  logic [7:0] read_lock;
  logic [7:0] write_lock;
  logic [15:0] core_pc;
  logic [15:0] core_addr;
  logic [15:0] jtag_addr;
  logic core_blocked;
  logic core_is_lock;
  logic core_sec_page;
  logic jtag_read_ok;
  logic jtag_write_ok;
  logic jtag_is_lock;
  logic jtag_sec_byte;
  logic jtag_sec_page;

  modport judge (
    input read_limit, read_lock, write_lock, core_pc, core_addr, jtag_addr,
    output core_blocked, core_is_lock, core_sec_page,
    output jtag_read_ok, jtag_write_ok, jtag_is_lock, jtag_sec_byte, jtag_sec_page
  );

  modport owner (
    output read_limit, read_lock, write_lock, core_pc, core_addr, jtag_addr,
    input core_blocked, core_is_lock, core_sec_page,
    input jtag_read_ok, jtag_write_ok, jtag_is_lock, jtag_sec_byte, jtag_sec_page
  );
endinterface

// file: verilog/fsac_check.sv
module fsac_check #(
  parameter int BLOCK_SHIFT = fsac_pkg::BLOCK_SHIFT
) (
  fsac_chk_if.judge chk
);

  if (BLOCK_SHIFT + fsac_pkg::BLOCK_IDX_W > fsac_pkg::ADDR_W) begin : g_bad_shift
    $error("fsac_check: lock blocks do not fit the address space");
  end

  function automatic logic lock_open(input logic [7:0] lb, input logic [15:0] a);
    lock_open = lb[a[BLOCK_SHIFT +: fsac_pkg::BLOCK_IDX_W]];
  endfunction

  function automatic logic in_sec_page(input logic [15:0] a);
    in_sec_page = (a >= fsac_pkg::SEC_PAGE_BASE) && (a <= fsac_pkg::SEC_PAGE_LAST);
  endfunction

  function automatic logic is_lock_byte(input logic [15:0] a);
    is_lock_byte = (a == fsac_pkg::READ_LOCK_ADDR) || (a == fsac_pkg::WRITE_LOCK_ADDR);
  endfunction

  // Upper code may not touch lower data; lower code is free
  assign chk.core_blocked = (chk.core_pc >= chk.read_limit) &&
                            (chk.core_addr < chk.read_limit);
  assign chk.core_is_lock = is_lock_byte(chk.core_addr);
  assign chk.core_sec_page = in_sec_page(chk.core_addr);
  assign chk.jtag_read_ok = lock_open(chk.read_lock, chk.jtag_addr) ||
                            is_lock_byte(chk.jtag_addr);
  assign chk.jtag_write_ok = lock_open(chk.write_lock, chk.jtag_addr) ||
                             is_lock_byte(chk.jtag_addr);
  assign chk.jtag_is_lock = is_lock_byte(chk.jtag_addr);
  assign chk.jtag_sec_byte = is_lock_byte(chk.jtag_addr) ||
                             (chk.jtag_addr == fsac_pkg::LIMIT_BYTE_ADDR);
  assign chk.jtag_sec_page = in_sec_page(chk.jtag_addr);

endmodule // fsac_check

// file: verification/fsac_flash_guard_properties.sv
module fsac_flash_guard_properties (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic core_req_in,
  input wire logic [1:0] core_op_in,
  input wire logic [15:0] core_pc_in,
  input wire logic [15:0] core_addr_in,
  input wire logic core_ready_out,
  input wire logic core_rvalid_out,
  input wire logic core_denied_out,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic jtag_req_in,
  input wire logic [1:0] jtag_op_in,
  input wire logic jtag_ready_out,
  input wire logic jtag_rvalid_out,
  input wire logic jtag_denied_out,
  input wire logic flash_rd_out,
  input wire logic flash_prog_out,
  input wire logic flash_page_erase_out,
  input wire logic flash_mass_erase_out,
  input wire logic [15:0] flash_addr_out,
  input wire logic guard_ready_out,
  input wire logic [15:0] software_read_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence core_taken(logic [1:0] op);
    core_req_in && core_ready_out && core_op_in == op;
  endsequence

  sequence jtag_taken(logic [1:0] op);
    jtag_req_in && jtag_ready_out && jtag_op_in == op;
  endsequence

  limit_low_zero_a: assert property (software_read_limit_out[7:0] == 8'h00)
    else $error("read limit low byte not zero");

  upper_read_block_a: assert property (core_taken(fsac_pkg::CORE_TABLE_READ)
    ##0 (core_pc_in >= software_read_limit_out && core_addr_in < software_read_limit_out
    && core_addr_in < fsac_pkg::WRITE_LOCK_ADDR) |=> core_denied_out && !flash_rd_out)
    else $error("upper read not refused");

  lower_read_free_a: assert property (core_taken(fsac_pkg::CORE_TABLE_READ)
    ##0 core_pc_in < software_read_limit_out
    |=> flash_rd_out && flash_addr_out == $past(core_addr_in))
    else $error("lower read not passed on");

  fetch_pass_a: assert property (core_taken(fsac_pkg::CORE_FETCH)
    |=> flash_rd_out && !core_denied_out)
    else $error("fetch refused");

  read_answer_a: assert property (guard_ready_out && flash_rd_out
    |-> ##2 (core_rvalid_out || jtag_rvalid_out))
    else $error("read answer late");

  psc_upper_zero_a: assert property (sfr_rd_in && sfr_addr_in == fsac_pkg::PSC_OFFSET
    |=> sfr_rdata_out[7:2] == 6'h00)
    else $error("control upper bits set");

  mass_erase_a: assert property (jtag_taken(fsac_pkg::JT_MASS_ERASE)
    |=> flash_mass_erase_out && !core_ready_out)
    else $error("mass erase strobe missing");

  denied_quiet_a: assert property (core_denied_out || jtag_denied_out
    |-> !(flash_prog_out || flash_page_erase_out || flash_rd_out))
    else $error("refused request reached the array");

  prog_cause_a: assert property (flash_prog_out
    |-> $past(core_req_in && core_ready_out || jtag_req_in && jtag_ready_out))
    else $error("stray program strobe");
endmodule // fsac_flash_guard_properties

bind fsac_flash_guard fsac_flash_guard_properties chk_u (
  .clk_sys_in, .sys_rst_in, .core_req_in, .core_op_in, .core_pc_in, .core_addr_in,
  .core_ready_out, .core_rvalid_out, .core_denied_out, .sfr_addr_in, .sfr_rd_in, .sfr_rdata_out,
  .jtag_req_in, .jtag_op_in, .jtag_ready_out, .jtag_rvalid_out, .jtag_denied_out, .flash_rd_out,
  .flash_prog_out, .flash_page_erase_out, .flash_mass_erase_out, .flash_addr_out,
  .guard_ready_out, .software_read_limit_out);

// file: verification/fsac_flash_model.sv
module fsac_flash_model #(
  parameter logic [7:0] LIMIT_INIT = 8'h10,
  parameter logic [7:0] LOCK_INIT = 8'hFE
) (
  input wire logic clk_sys_in,
  input wire logic rd_in,
  input wire logic prog_in,
  input wire logic page_erase_in,
  input wire logic mass_erase_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] busy_r = 2'h0;
  logic [7:0] rdata_r = 8'hA5;

  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8];
    mem[16'h1DFD] = LIMIT_INIT;
    mem[16'h1DFE] = LOCK_INIT;
    mem[16'h1DFF] = LOCK_INIT;
  end

  // Data toggles when not read so a stale byte is never mistaken for valid
  always @(posedge clk_sys_in) begin
    rdata_r <= rd_in ? mem[addr_in] : ~rdata_r;
    if (prog_in) mem[addr_in] <= mem[addr_in] & wdata_in;
    if (page_erase_in) for (int i = 0; i < 512; i++) mem[{addr_in[15:9], 9'h000} + i] <= 8'hFF;
    if (mass_erase_in) for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
    if (prog_in || page_erase_in || mass_erase_in) busy_r <= 2'h2;
    else if (busy_r != 2'h0) busy_r <= busy_r - 2'h1;
  end
  assign rdata_out = rdata_r;
  assign busy_out = busy_r != 2'h0;
endmodule // fsac_flash_model

// file: verification/fsac_flash_guard_tb.sv
module fsac_flash_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
  typedef struct {logic jt; logic [1:0] op; logic [15:0] pc, addr; logic [7:0] ex; logic den;} fsac_row_t;
  logic clk_sys_in = 0, sys_rst_in = 1, core_req_in = 0, sfr_wr_in = 0, sfr_rd_in = 0;
  logic jtag_req_in = 0, flash_busy_in, core_ready_out, core_rvalid_out, core_denied_out;
  logic [1:0] core_op_in = 0, jtag_op_in = 0;
  logic [15:0] core_pc_in = 0, core_addr_in = 0, jtag_addr_in = 0, software_read_limit_out;
  logic [7:0] core_wdata_in = 0, sfr_addr_in = 0, sfr_wdata_in = 0, jtag_wdata_in = 0;
  logic [7:0] flash_rdata_in, core_rdata_out, sfr_rdata_out, jtag_rdata_out, flash_wdata_out;
  logic jtag_ready_out, jtag_rvalid_out, jtag_denied_out, flash_rd_out, flash_prog_out;
  logic flash_page_erase_out, flash_mass_erase_out, guard_ready_out;
  logic [15:0] flash_addr_out;
  int num_errors = 0, comparisons = 0;
  fsac_row_t rows [8] = '{
    '{0, 2'h0, 16'h1200, 16'h0100, 8'h01, 0},
    '{0, 2'h1, 16'h1200, 16'h0100, 8'h00, 1},
    '{0, 2'h1, 16'h1200, 16'h1000, 8'h10, 0},
    '{0, 2'h1, 16'h1200, 16'h0FFF, 8'h00, 1},
    '{0, 2'h1, 16'h0FFF, 16'h0100, 8'h01, 0},
    '{0, 2'h1, 16'h1200, 16'h1DFF, 8'hFE, 0},
    '{1, 2'h0, 16'h0000, 16'h0100, 8'h00, 1},
    '{1, 2'h0, 16'h0000, 16'h0400, 8'h04, 0}};

  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  fsac_flash_guard dut_u (.clk_sys_in, .sys_rst_in, .core_req_in, .core_op_in, .core_pc_in,
    .core_addr_in, .core_wdata_in, .core_ready_out, .core_rvalid_out, .core_rdata_out,
    .core_denied_out, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .jtag_req_in, .jtag_op_in, .jtag_addr_in, .jtag_wdata_in, .jtag_ready_out, .jtag_rvalid_out,
    .jtag_rdata_out, .jtag_denied_out, .flash_busy_in, .flash_rdata_in, .flash_rd_out,
    .flash_prog_out, .flash_page_erase_out, .flash_mass_erase_out, .flash_addr_out,
    .flash_wdata_out, .guard_ready_out, .software_read_limit_out);

  fsac_flash_model flash_u (.clk_sys_in(clk_sys_in), .rd_in(flash_rd_out),
    .prog_in(flash_prog_out), .page_erase_in(flash_page_erase_out),
    .mass_erase_in(flash_mass_erase_out), .addr_in(flash_addr_out), .wdata_in(flash_wdata_out),
    .rdata_out(flash_rdata_in), .busy_out(flash_busy_in));

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset();
    int n = 0;
    sys_rst_in = 1;
    repeat (6) @(negedge clk_sys_in);
    sys_rst_in = 0;
    while (guard_ready_out !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("guard ready", 1'b1, guard_ready_out)
  endtask

  // Called at a falling edge; request held until the edge that sees ready
  task automatic acc(input logic jt, input logic [1:0] op, input logic [15:0] pc, a,
    input logic [7:0] wd, output logic [7:0] rd, output logic den, output logic [2:0] st);
    int n = 0;
    den = 0;
    st = 0;
    core_op_in = op;
    jtag_op_in = op;
    core_pc_in = pc;
    core_addr_in = a;
    jtag_addr_in = a;
    core_wdata_in = wd;
    jtag_wdata_in = wd;
    if (jt) jtag_req_in = 1;
    else core_req_in = 1;
    while ((jt ? jtag_ready_out : core_ready_out) !== 1'b1 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      $display("Error ready expected 1 seen 0");
      print_verdict();
    end
    @(negedge clk_sys_in);
    core_req_in = 0;
    jtag_req_in = 0;
    repeat (4) begin
      den |= jt ? jtag_denied_out : core_denied_out;
      st |= {flash_mass_erase_out, flash_page_erase_out, flash_prog_out};
      @(negedge clk_sys_in);
    end
    rd = jt ? jtag_rdata_out : core_rdata_out;
  endtask

  task automatic sfr(input logic wr, input logic [7:0] a, d, output logic [7:0] rd);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = wr;
    sfr_rd_in = !wr;
    @(negedge clk_sys_in);
    sfr_wr_in = 0;
    sfr_rd_in = 0;
    rd = sfr_rdata_out;
  endtask

  initial begin
    logic [7:0] rd;
    logic den;
    logic [2:0] st;
    do_reset();
    `CHK("limit", 16'h1000, software_read_limit_out)
    sfr(0, 8'h8F, 8'h00, rd);
    `CHK("control reset", 8'h00, rd)
    foreach (rows[i]) begin
      acc(rows[i].jt, rows[i].op, rows[i].pc, rows[i].addr, 8'h00, rd, den, st);
      `CHK("row data", rows[i].ex, rd)
      `CHK("row denied", rows[i].den, den)
    end
    $display("Test read table done");
    sfr(1, 8'h8F, 8'hFF, rd);
    sfr(0, 8'h8F, 8'h00, rd);
    `CHK("control bits", 8'h03, rd)
    sfr(0, 8'h90, 8'h00, rd);
    `CHK("unmapped", 8'h00, rd)
    sfr(1, 8'h8F, 8'h00, rd);
    acc(0, 2'h2, 16'h1200, 16'h1100, 8'h5A, rd, den, st);
    `CHK("write off", 4'h0, {st, den})
    sfr(1, 8'h8F, 8'h03, rd);
    acc(0, 2'h2, 16'h1200, 16'h1100, 8'h00, rd, den, st);
    `CHK("page erase", 3'b010, st)
    sfr(1, 8'h8F, 8'h01, rd);
    acc(0, 2'h2, 16'h1200, 16'h1100, 8'h5A, rd, den, st);
    `CHK("program", 3'b001, st)
    acc(0, 2'h1, 16'h1200, 16'h1100, 8'h00, rd, den, st);
    `CHK("readback", 8'h5A, rd)
    acc(0, 2'h2, 16'h1200, 16'h0200, 8'h00, rd, den, st);
    `CHK("blocked write", 4'h1, {st, den})
    acc(0, 2'h3, 16'h1200, 16'h1100, 8'h00, rd, den, st);
    `CHK("illegal op", 4'h1, {st, den})
    acc(0, 2'h1, 16'h0FFF, 16'h0200, 8'h00, rd, den, st);
    `CHK("untouched", 8'h02, rd)
    sfr(1, 8'h8F, 8'h03, rd);
    acc(0, 2'h2, 16'h1200, 16'h1C10, 8'h00, rd, den, st);
    `CHK("core sec erase", 4'h1, {st, den})
    $display("Test data move done");
    acc(1, 2'h1, 16'h0000, 16'h0100, 8'h00, rd, den, st);
    `CHK("jtag locked write", 4'h1, {st, den})
    acc(1, 2'h1, 16'h0000, 16'h1DFF, 8'h00, rd, den, st);
    acc(1, 2'h0, 16'h0000, 16'h0400, 8'h00, rd, den, st);
    `CHK("lock cleared", 1'b1, den)
    acc(1, 2'h3, 16'h0000, 16'h0000, 8'h00, rd, den, st);
    `CHK("mass erase", 3'b100, st)
    acc(1, 2'h0, 16'h0000, 16'h0100, 8'h00, rd, den, st);
    `CHK("unlocked read", 9'h0FF, {den, rd})
    acc(1, 2'h2, 16'h0000, 16'h1C10, 8'h00, rd, den, st);
    `CHK("jtag page erase", 3'b010, st)
    acc(1, 2'h2, 16'h0000, 16'h1DFD, 8'h00, rd, den, st);
    `CHK("jtag sec erase", 3'b100, st)
    $display("Test locks done");
    flash_u.mem[16'h1DFD] = 8'h00;
    do_reset();
    `CHK("unprog limit", 16'h0000, software_read_limit_out)
    acc(0, 2'h1, 16'h1200, 16'h0100, 8'h00, rd, den, st);
    `CHK("open read", 9'h0FF, {den, rd})
    $display("Test reset limit done");
    print_verdict();
  end
endmodule // fsac_flash_guard_tb
